/* File: src/scs_defines.svh */
// constants for the serial configuration host: addresses, codes, timing, reset values
`ifndef SCS_DEFINES_SVH
`define SCS_DEFINES_SVH

`define SCS_DEV_ADDR 7'h69
`define SCS_RW_WRITE 1'h0
`define SCS_RW_READ 1'h1
`define SCS_CMD_BYTE_MODE 1'h1
`define SCS_CMD_BLOCK 8'h00

`define SCS_CLK_PERIOD_NS 50
`define SCS_T_QTR_NS 2500
`define SCS_QTR_CYC ((`SCS_T_QTR_NS + `SCS_CLK_PERIOD_NS - 1) / `SCS_CLK_PERIOD_NS)
`define SCS_QC_W 8

`define SCS_ACK_BIT 4'h8
`define SCS_Q0 2'h0
`define SCS_Q1 2'h1
`define SCS_Q2 2'h2
`define SCS_Q3 2'h3

`define SCS_SYNC_RST 3'h7
`define SCS_ZERO8 8'h00
`define SCS_ONE8 8'h01

`endif

/* File: src/scs_host.sv */
// two-wire bus master that reads and writes the synthesizer configuration bytes
`include "scs_defines.svh"
// Operation
// (R1) The device loads its defaults at power-up, so the host need not issue any transfer.
// (R2) The host offers byte write, byte read, block write and block read.
// (R3) Block bytes go in ascending order from byte zero, each most significant bit first.
// (R4) The host may end a block after any whole byte and the device keeps what was done.
// (R5) The device answers only address byte 8'hd2 with its read/write bit.
// (R6) Command bit 7 low means block, high means single byte.
// (R7) Command bits 6:0 index a single byte and are all zero for a block.
// (R8) Every block transfer starts with the write address and an all-zero command.
// (R9) Block write sends address, command, count and data with a device acknowledge on each, then stop.
// (R10) Block read sends command, repeated start, read address, takes count and data, acknowledging each, then stop.
// (R11) A single-byte command carries the byte mode pattern in its upper bits and the index below.
// (R12) Byte write sends address, command, one data byte, each acknowledged, then stop.
// (R13) Byte read sends the command, repeated start, read address, takes one byte, acknowledges it, then stop.
// (R14) The device gates each clock output from its configuration bits.
// (R15) Configuration is meant for system start and not for power management in operation.
// (R16) The device leaves the data line released for any foreign address.
module scs_host #(
  parameter int DEPTH = 128,
  parameter int AW = 7
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // request
  input wire logic start_in,
  input wire logic [1:0] op_in,
  input wire logic [6:0] index_in,
  input wire logic [7:0] count_in,
  input wire logic [7:0] wdata_in,
  // status and result
  output logic busy_out,
  output logic done_out,
  output logic nack_out,
  output logic [7:0] rdata_out,
  output logic [7:0] rx_count_out,
  // block buffer
  input wire logic buf_we_in,
  input wire logic [AW-1:0] buf_waddr_in,
  input wire logic [7:0] buf_wdata_in,
  input wire logic [AW-1:0] buf_raddr_in,
  output logic [7:0] buf_rdata_out,
  // bus pins, open drain
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out
);
  function automatic logic bit_of(input logic [7:0] b, input logic [2:0] i);
    bit_of = b[3'h7 - i];
  endfunction : bit_of

  scs_mem_if #(.AW(AW)) mif ();

  scs_mem #(.DEPTH(DEPTH), .AW(AW)) u_mem (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .mif(mif)
  );

  // pin synchronisers
  logic [2:0] scl_sy_r, scl_sy_nxt, sda_sy_r, sda_sy_nxt;
  logic scl_s_r, scl_s_nxt, sda_s_r, sda_s_nxt;

  always_comb begin
    scl_sy_nxt = {scl_sy_r[1:0], scl_in};
    sda_sy_nxt = {sda_sy_r[1:0], sda_in};
    scl_s_nxt = (scl_sy_r[1] == scl_sy_r[2]) ? scl_sy_r[2] : scl_s_r;
    sda_s_nxt = (sda_sy_r[1] == sda_sy_r[2]) ? sda_sy_r[2] : sda_s_r;
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      scl_sy_r <= `SCS_SYNC_RST;
      sda_sy_r <= `SCS_SYNC_RST;
      scl_s_r <= 1'h1;
      sda_s_r <= 1'h1;
    end else begin
      scl_sy_r <= scl_sy_nxt;
      sda_sy_r <= sda_sy_nxt;
      scl_s_r <= scl_s_nxt;
      sda_s_r <= sda_s_nxt;
    end
  end

  // engine
  scs_pkg::scs_state_t st_r, st_nxt;
  scs_pkg::scs_phase_t ph_r, ph_nxt;
  logic [1:0] op_r, op_nxt, q_r, q_nxt;
  logic [`SCS_QC_W-1:0] qc_r, qc_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] sh_r, sh_nxt, cnt_r, cnt_nxt, lim_r, lim_nxt, n_r, n_nxt;
  logic [7:0] wd_r, wd_nxt, rd_r, rd_nxt, rxc_r, rxc_nxt, wdat_r, wdat_nxt;
  logic [6:0] idx_r, idx_nxt;
  logic [AW-1:0] wa_r, wa_nxt;
  logic busy_r, busy_nxt, done_r, done_nxt, nack_r, nack_nxt, we_r, we_nxt;
  logic scl_oe_r, scl_oe_nxt, sda_oe_r, sda_oe_nxt, rs_r, rs_nxt, msrc_r, msrc_nxt;
  logic adv, qlast, rx_ph, blk, rd_op;

  // only the first high quarter waits on the line, so a stretched clock just delays us
  assign adv = !(q_r == `SCS_Q2 && !scl_s_r);
  assign qlast = (qc_r == `SCS_QC_W'(`SCS_QTR_CYC - 1));
  assign rx_ph = (ph_r == scs_pkg::PH_COUNT_R) || (ph_r == scs_pkg::PH_DATA_R);
  assign blk = op_r[1];
  assign rd_op = op_r[0];

  always_comb begin
    logic [7:0] b;
    b = sh_r;
    {st_nxt, ph_nxt, op_nxt, q_nxt, qc_nxt, bit_nxt} = {st_r, ph_r, op_r, q_r, qc_r, bit_r};
    {sh_nxt, cnt_nxt, lim_nxt, n_nxt, wd_nxt, rd_nxt, rxc_nxt} = {sh_r, cnt_r, lim_r, n_r, wd_r, rd_r, rxc_r};
    {idx_nxt, wa_nxt, wdat_nxt, busy_nxt, nack_nxt} = {idx_r, wa_r, wdat_r, busy_r, nack_r};
    {scl_oe_nxt, sda_oe_nxt, rs_nxt, msrc_nxt} = {scl_oe_r, sda_oe_r, rs_r, msrc_r};
    done_nxt = 1'h0;
    we_nxt = 1'h0;
    unique case (st_r)
      scs_pkg::ST_IDLE: begin
        if (start_in) begin // R15
          {busy_nxt, nack_nxt, rs_nxt, msrc_nxt} = 4'h8;
          {op_nxt, idx_nxt, cnt_nxt, wd_nxt} = {op_in, index_in, count_in, wdata_in};
          {q_nxt, qc_nxt, n_nxt} = '0;
          ph_nxt = scs_pkg::PH_ADDR_W;
          sh_nxt = {`SCS_DEV_ADDR, `SCS_RW_WRITE}; // R5 R8
          st_nxt = scs_pkg::ST_START;
          scl_oe_nxt = 1'h0;
        end
      end
      default: begin
        if (adv) begin
          qc_nxt = qlast ? '0 : `SCS_QC_W'(qc_r + `SCS_QC_W'(1));
          if (qlast) begin
            q_nxt = q_r + 2'h1;
            unique case (q_r)
              `SCS_Q0: begin
                if (st_r == scs_pkg::ST_START) begin
                  sda_oe_nxt = 1'h0;
                end else if (st_r == scs_pkg::ST_STOP) begin
                  sda_oe_nxt = 1'h1;
                end else if (bit_r == `SCS_ACK_BIT) begin
                  sda_oe_nxt = rx_ph; // R10 R13
                end else if (rx_ph) begin
                  sda_oe_nxt = 1'h0; // R13
                end else begin
                  if (bit_r == 4'h0 && msrc_r) begin
                    b = mif.rdata_b;
                    sh_nxt = b;
                  end
                  sda_oe_nxt = !b[7]; // R3
                end
              end
              `SCS_Q1: scl_oe_nxt = 1'h0;
              `SCS_Q2: begin
                // data moves while the clock is high only to frame a start or stop
                if (st_r == scs_pkg::ST_START) begin
                  sda_oe_nxt = 1'h1;
                end else if (st_r == scs_pkg::ST_STOP) begin
                  sda_oe_nxt = 1'h0;
                end
              end
              `SCS_Q3: begin
                scl_oe_nxt = 1'h1;
                if (st_r == scs_pkg::ST_START) begin
                  st_nxt = scs_pkg::ST_BIT;
                  bit_nxt = 4'h0;
                end else if (st_r == scs_pkg::ST_STOP) begin
                  st_nxt = scs_pkg::ST_IDLE;
                  {busy_nxt, done_nxt, scl_oe_nxt} = 3'h2;
                end else if (bit_r != `SCS_ACK_BIT) begin
                  sh_nxt = {sh_r[6:0], sda_s_r}; // R3
                  bit_nxt = bit_r + 4'h1;
                end else begin
                  bit_nxt = 4'h0;
                  msrc_nxt = 1'h0;
                  if (!rx_ph && sda_s_r) begin
                    nack_nxt = 1'h1; // R16
                    st_nxt = scs_pkg::ST_STOP;
                  end else begin
                    unique case (ph_r)
                      scs_pkg::PH_ADDR_W: begin
                        ph_nxt = scs_pkg::PH_CMD;
                        sh_nxt = blk ? `SCS_CMD_BLOCK : {`SCS_CMD_BYTE_MODE, idx_r}; // R6 R7 R8 R11
                      end
                      scs_pkg::PH_CMD: begin
                        if (rd_op) begin
                          st_nxt = scs_pkg::ST_START; // R10 R13
                          rs_nxt = 1'h1;
                          ph_nxt = scs_pkg::PH_ADDR_R;
                          sh_nxt = {`SCS_DEV_ADDR, `SCS_RW_READ};
                        end else begin
                          ph_nxt = blk ? scs_pkg::PH_COUNT_W : scs_pkg::PH_DATA_W; // R9 R12
                          sh_nxt = blk ? cnt_r : wd_r;
                        end
                      end
                      scs_pkg::PH_COUNT_W: begin
                        ph_nxt = scs_pkg::PH_DATA_W;
                        msrc_nxt = 1'h1;
                        if (cnt_r == `SCS_ZERO8) begin
                          st_nxt = scs_pkg::ST_STOP;
                        end
                      end
                      scs_pkg::PH_DATA_W: begin
                        n_nxt = 8'(n_r + `SCS_ONE8); // R3
                        msrc_nxt = 1'h1;
                        if (!blk || n_nxt == cnt_r) begin
                          st_nxt = scs_pkg::ST_STOP; // R4 R9 R12
                        end
                      end
                      scs_pkg::PH_ADDR_R: ph_nxt = blk ? scs_pkg::PH_COUNT_R : scs_pkg::PH_DATA_R;
                      scs_pkg::PH_COUNT_R: begin
                        rxc_nxt = sh_r;
                        lim_nxt = (sh_r < cnt_r) ? sh_r : cnt_r; // R4
                        ph_nxt = scs_pkg::PH_DATA_R;
                        if (lim_nxt == `SCS_ZERO8) begin
                          st_nxt = scs_pkg::ST_STOP;
                        end
                      end
                      scs_pkg::PH_DATA_R: begin
                        if (!blk) begin
                          rd_nxt = sh_r;
                          st_nxt = scs_pkg::ST_STOP; // R13
                        end else begin
                          we_nxt = 1'h1;
                          wa_nxt = n_r[AW-1:0];
                          wdat_nxt = sh_r;
                          n_nxt = 8'(n_r + `SCS_ONE8); // R3
                          if (n_nxt == lim_r) begin
                            st_nxt = scs_pkg::ST_STOP; // R4 R10
                          end
                        end
                      end
                      default: st_nxt = scs_pkg::ST_STOP;
                    endcase
                  end
                end
              end
            endcase
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      st_r <= scs_pkg::ST_IDLE;
      ph_r <= scs_pkg::PH_ADDR_W;
      {op_r, q_r, qc_r, bit_r, sh_r, cnt_r, lim_r, n_r, wd_r, rd_r, rxc_r} <= '0;
      {idx_r, wa_r, wdat_r, busy_r, done_r, nack_r, we_r} <= '0;
      {scl_oe_r, sda_oe_r, rs_r, msrc_r} <= '0;
    end else begin
      st_r <= st_nxt;
      ph_r <= ph_nxt;
      {op_r, q_r, qc_r, bit_r, sh_r, cnt_r, lim_r, n_r, wd_r, rd_r, rxc_r} <=
        {op_nxt, q_nxt, qc_nxt, bit_nxt, sh_nxt, cnt_nxt, lim_nxt, n_nxt, wd_nxt, rd_nxt, rxc_nxt};
      {idx_r, wa_r, wdat_r, busy_r, done_r, nack_r, we_r} <=
        {idx_nxt, wa_nxt, wdat_nxt, busy_nxt, done_nxt, nack_nxt, we_nxt};
      {scl_oe_r, sda_oe_r, rs_r, msrc_r} <= {scl_oe_nxt, sda_oe_nxt, rs_nxt, msrc_nxt};
    end
  end

  // buffer ports: the engine owns the write port while busy, user loads are dropped then
  assign mif.we = busy_r ? we_r : buf_we_in;
  assign mif.waddr = busy_r ? wa_r : buf_waddr_in;
  assign mif.wdata = busy_r ? wdat_r : buf_wdata_in;
  assign mif.raddr_a = buf_raddr_in;
  assign mif.raddr_b = n_r[AW-1:0];

  assign {busy_out, done_out, nack_out, rdata_out, rx_count_out} = {busy_r, done_r, nack_r, rd_r, rxc_r};
  assign buf_rdata_out = mif.rdata_a;
  assign {scl_out, sda_out, scl_oe_out, sda_oe_out} = {1'h0, 1'h0, scl_oe_r, sda_oe_r};

  sda_frame_a: assert property (@(posedge clock_in) disable iff (reset_in) // R9
    $changed(sda_oe_r) && !scl_oe_r |-> (st_r == scs_pkg::ST_START || st_r == scs_pkg::ST_STOP) && q_r == `SCS_Q3)
    else $error("data line moved while clock high outside start or stop");
  addr_bits_a: assert property (@(posedge clock_in) disable iff (reset_in) // R8 R10 R13
    st_r == scs_pkg::ST_BIT && (ph_r == scs_pkg::PH_ADDR_W || ph_r == scs_pkg::PH_ADDR_R)
    && bit_r < `SCS_ACK_BIT && q_r == `SCS_Q2
    |-> sda_oe_r == !bit_of({`SCS_DEV_ADDR, rs_r}, bit_r[2:0]) && rs_r == (ph_r == scs_pkg::PH_ADDR_R))
    else $error("address bit wrong");
  block_cmd_a: assert property (@(posedge clock_in) disable iff (reset_in) // R8
    st_r == scs_pkg::ST_BIT && ph_r == scs_pkg::PH_CMD && blk && bit_r < `SCS_ACK_BIT && q_r == `SCS_Q2
    |-> sda_oe_r)
    else $error("block command not all zero");
  byte_cmd_a: assert property (@(posedge clock_in) disable iff (reset_in) // R11
    st_r == scs_pkg::ST_BIT && ph_r == scs_pkg::PH_CMD && !blk && bit_r < `SCS_ACK_BIT && q_r == `SCS_Q2
    |-> sda_oe_r == !bit_of({`SCS_CMD_BYTE_MODE, idx_r}, bit_r[2:0]))
    else $error("byte command bit wrong");
  master_ack_a: assert property (@(posedge clock_in) disable iff (reset_in) // R10
    st_r == scs_pkg::ST_BIT && rx_ph && q_r == `SCS_Q2 |-> sda_oe_r == (bit_r == `SCS_ACK_BIT))
    else $error("read byte not released or not acknowledged");
  nack_abort_a: assert property (@(posedge clock_in) disable iff (reset_in) // R16
    st_r == scs_pkg::ST_BIT && !rx_ph && bit_r == `SCS_ACK_BIT && q_r == `SCS_Q3 && qlast && sda_s_r
    |=> st_r == scs_pkg::ST_STOP && nack_r ##1 scl_oe_r)
    else $error("missing acknowledge did not end the transfer");
  early_end_a: assert property (@(posedge clock_in) disable iff (reset_in) // R4
    st_r == scs_pkg::ST_BIT && ph_r == scs_pkg::PH_DATA_W && blk && bit_r == `SCS_ACK_BIT && q_r == `SCS_Q3
    && qlast && !sda_s_r && 8'(n_r + `SCS_ONE8) == cnt_r |=> st_r == scs_pkg::ST_STOP)
    else $error("block write ran past its count");
  start_take_a: assert property (@(posedge clock_in) disable iff (reset_in) // R2
    st_r == scs_pkg::ST_IDLE && start_in |=> busy_r && st_r == scs_pkg::ST_START && !done_r)
    else $error("request not taken");
  done_end_a: assert property (@(posedge clock_in) disable iff (reset_in) // R12
    done_r |-> !busy_r && !scl_oe_r && !sda_oe_r ##1 !done_r)
    else $error("done without released bus");
endmodule : scs_host

/* File: src/scs_mem.sv */
// block buffer: one write port, two registered read ports
`include "scs_defines.svh"
module scs_mem #(
  parameter int DEPTH = 128,
  parameter int AW = 7
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // buffer access
  scs_mem_if.mem mif
);
  logic [7:0] ram [DEPTH];

  // data cells carry no reset; only the read registers do
  always_ff @(posedge clock_in) begin
    if (mif.we) begin
      ram[mif.waddr] <= mif.wdata;
    end
    if (reset_in) begin
      mif.rdata_a <= `SCS_ZERO8;
      mif.rdata_b <= `SCS_ZERO8;
    end else begin
      mif.rdata_a <= ram[mif.raddr_a];
      mif.rdata_b <= ram[mif.raddr_b];
    end
  end
endmodule : scs_mem

/* File: src/scs_mem_if.sv */
// carrier between the host engine and its block buffer
interface scs_mem_if #(
  parameter int AW = 7
);
  logic we;
  logic [AW-1:0] waddr;
  logic [7:0] wdata;
  logic [AW-1:0] raddr_a;
  logic [7:0] rdata_a;
  logic [AW-1:0] raddr_b;
  logic [7:0] rdata_b;

  modport ctl (output we, output waddr, output wdata, output raddr_a, output raddr_b,
               input rdata_a, input rdata_b);
  modport mem (input we, input waddr, input wdata, input raddr_a, input raddr_b,
               output rdata_a, output rdata_b);
endinterface : scs_mem_if

/* File: src/scs_pkg.sv */
// types of the serial configuration host
package scs_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_START = 2'h1,
    ST_BIT = 2'h3,
    ST_STOP = 2'h2
  } scs_state_t;

  typedef enum logic [2:0] {
    PH_ADDR_W = 3'h0,
    PH_CMD = 3'h1,
    PH_COUNT_W = 3'h3,
    PH_DATA_W = 3'h2,
    PH_ADDR_R = 3'h6,
    PH_COUNT_R = 3'h7,
    PH_DATA_R = 3'h5
  } scs_phase_t;

  // bit 1 selects block, bit 0 selects read
  typedef enum logic [1:0] {
    OP_BYTE_WR = 2'h0,
    OP_BYTE_RD = 2'h1,
    OP_BLK_WR = 2'h2,
    OP_BLK_RD = 2'h3
  } scs_op_t;

endpackage : scs_pkg

/* File: tb/scs_dev_model.sv */
// behavioural configuration slave on the far side of the two-wire bus
module scs_dev_model #(
  parameter int NBYTES = 8,
  parameter logic [1:0] STRAP = 2'h0
) (
  // bus wire levels
  input wire logic scl_in,
  input wire logic sda_in,
  // pulls, high = line held low
  output logic scl_oe_out,
  output logic sda_oe_out,
  // commanded misbehaviour
  input wire logic mute_in,
  input wire logic slow_in
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] mem [NBYTES];
  logic [7:0] last_addr;
  logic [7:0] last_cmd;
  logic [6:0] idx;
  logic byte_mode = 1'b0;
  logic restart;

  initial begin
    scl_oe_out = 1'b0;
    sda_oe_out = 1'b0;
    for (int i = 0; i < NBYTES; i++) mem[i] = 8'h00;
    mem[0] = {6'h13, STRAP};
    mem[1] = 8'h7f;
    mem[3] = 8'hff;
  end

  // one bit slot: change data while the clock is low, sample on its rise
  task automatic bit_io(input logic drv, output logic smp);
    @(negedge scl_in);
    sda_oe_out = drv;
    @(posedge scl_in);
    smp = sda_in;
  endtask : bit_io

  task automatic get_byte(output logic [7:0] v);
    for (int i = 7; i >= 0; i--) bit_io(1'b0, v[i]);
  endtask : get_byte

  task automatic put_byte(input logic [7:0] v, output logic acked);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(!v[i], s);
    bit_io(1'b0, s);
    acked = !s;
  endtask : put_byte

  task automatic transact();
    logic [7:0] a;
    logic k;
    get_byte(last_addr);
    if (last_addr[7:1] != 7'h69) return;
    // muted: keep listening but leave the acknowledge slot released
    bit_io(!mute_in, k);
    if (!last_addr[0]) begin
      get_byte(last_cmd);
      bit_io(1'b1, k);
      byte_mode = last_cmd[7];
      idx = byte_mode ? last_cmd[6:0] : 7'h00;
      get_byte(a);
      bit_io(1'b1, k);
      if (byte_mode) begin
        mem[idx] = a;
        @(negedge scl_in);
        sda_oe_out = 1'b0;
        return;
      end
      // count byte taken, data runs until the stop cuts it short
      forever begin
        get_byte(a);
        bit_io(1'b1, k);
        if (idx < NBYTES) mem[idx] = a;
        idx++;
      end
    end else if (byte_mode) begin
      put_byte(mem[idx], k);
    end else begin
      put_byte(NBYTES, k);
      while (k) begin
        put_byte(idx < NBYTES ? mem[idx] : 8'hff, k);
        idx++;
      end
    end
  endtask : transact

  // start and stop abort whatever slot the transfer was in
  initial forever begin
    @(negedge sda_in iff scl_in === 1'b1);
    restart = 1'b1;
    while (restart) begin
      restart = 1'b0;
      fork
        transact();
        @(posedge sda_in iff scl_in === 1'b1);
        begin
          @(negedge sda_in iff scl_in === 1'b1);
          restart = 1'b1;
        end
      join_any
      disable fork;
      sda_oe_out = 1'b0;
    end
  end

  // slow answer: hold the clock low past the host's release
  always @(negedge scl_in) begin
    if (slow_in) begin
      scl_oe_out = 1'b1;
      #6000;
      scl_oe_out = 1'b0;
    end
  end
endmodule : scs_dev_model

/* File: tb/tb.sv */
// testbench: host engine against the behavioural configuration slave
`include "scs_defines.svh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic start_in = 1'b0;
  logic [1:0] op_in = 2'h0;
  logic [6:0] index_in = 7'h00;
  logic [7:0] count_in = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic buf_we_in = 1'b0;
  logic [6:0] buf_waddr_in = 7'h00;
  logic [7:0] buf_wdata_in = 8'h00;
  logic [6:0] buf_raddr_in = 7'h00;
  logic mute = 1'b0;
  logic slow = 1'b0;
  logic busy, done, nack, scl_oe_h, sda_oe_h, scl_oe_d, sda_oe_d, scl, sda, scl_lvl, sda_lvl;
  logic [7:0] rdata, rx_count, buf_rdata;
  int mismatches = 0;
  int n_checks = 0;

  always #25 clock_in = ~clock_in;
  // open drain with pull-up
  assign scl = !(scl_oe_h | scl_oe_d);
  assign sda = !(sda_oe_h | sda_oe_d);

  scs_host u_scs_host (.clock_in(clock_in), .reset_in(reset_in), .start_in(start_in), .op_in(op_in),
    .index_in(index_in), .count_in(count_in), .wdata_in(wdata_in), .busy_out(busy), .done_out(done),
    .nack_out(nack), .rdata_out(rdata), .rx_count_out(rx_count), .buf_we_in(buf_we_in),
    .buf_waddr_in(buf_waddr_in), .buf_wdata_in(buf_wdata_in), .buf_raddr_in(buf_raddr_in),
    .buf_rdata_out(buf_rdata), .scl_in(scl), .scl_out(scl_lvl), .scl_oe_out(scl_oe_h), .sda_in(sda),
    .sda_out(sda_lvl),
    .sda_oe_out(sda_oe_h));
  scs_dev_model u_scs_dev_model (.scl_in(scl), .sda_in(sda), .scl_oe_out(scl_oe_d), .sda_oe_out(sda_oe_d),
    .mute_in(mute), .slow_in(slow));

  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #2;
  endtask : tick

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  // one request; span must match the number of bit slots on the wire
  task automatic run_op(input logic [1:0] op, input logic [6:0] idx, input logic [7:0] cnt,
                        input logic [7:0] wd, input int pos);
    int n;
    int q;
    q = 4 * `SCS_QTR_CYC;
    start_in = 1'b1;
    op_in = op;
    index_in = idx;
    count_in = cnt;
    wdata_in = wd;
    tick(1);
    start_in = 1'b0;
    tick(1);
    n = 2;
    check("busy", 8'h01, busy);
    while (done !== 1'b1 && n < 40000) begin
      tick(1);
      n++;
    end
    check("done", 8'h01, done);
    check("busy", 8'h00, busy);
    check("span", 8'h01, n >= pos * q && n <= pos * (q + 40) + 100);
  endtask : run_op

  task automatic s_reset();
    check("busy", 8'h00, busy);
    check("nack", 8'h00, nack);
    check("bus", 8'h00, {scl_oe_h, sda_oe_h});
    check("rdata", 8'h00, rdata);
    check("pin level", 8'h00, {scl_lvl, sda_lvl});
  endtask : s_reset

  task automatic s_byte_read(input logic [6:0] idx, input logic [7:0] exp);
    run_op(2'h1, idx, 8'h00, 8'h00, 39);
    check("rdata", exp, rdata);
    check("nack", 8'h00, nack);
    check("read addr", 8'hd3, u_scs_dev_model.last_addr);
    check("command", {1'b1, idx}, u_scs_dev_model.last_cmd);
  endtask : s_byte_read

  task automatic s_byte_write();
    run_op(2'h0, 7'h05, 8'h00, 8'ha5, 29);
    check("mem5", 8'ha5, u_scs_dev_model.mem[5]);
    check("mem4", 8'h00, u_scs_dev_model.mem[4]);
    check("command", 8'h85, u_scs_dev_model.last_cmd);
  endtask : s_byte_write

  task automatic s_block_write();
    for (int i = 0; i < 3; i++) begin
      buf_we_in = 1'b1;
      buf_waddr_in = 7'(i);
      buf_wdata_in = 8'(8'h11 * (i + 1) + 8'h80 * (i == 1));
      tick(1);
    end
    buf_we_in = 1'b0;
    run_op(2'h2, 7'h00, 8'h03, 8'h00, 56);
    check("command", 8'h00, u_scs_dev_model.last_cmd);
    check("mem0", 8'h11, u_scs_dev_model.mem[0]);
    check("mem1", 8'ha2, u_scs_dev_model.mem[1]);
    check("mem2", 8'h33, u_scs_dev_model.mem[2]);
    check("mem3", 8'hff, u_scs_dev_model.mem[3]);
    check("mem5", 8'ha5, u_scs_dev_model.mem[5]);
  endtask : s_block_write

  task automatic s_block_read();
    logic [7:0] exp [3] = '{8'h11, 8'ha2, 8'h33};
    run_op(2'h3, 7'h00, 8'h03, 8'h00, 66);
    check("rx count", 8'h08, rx_count);
    check("command", 8'h00, u_scs_dev_model.last_cmd);
    for (int i = 0; i < 3; i++) begin
      buf_raddr_in = 7'(i);
      tick(1);
      check("buffer", exp[i], buf_rdata);
    end
  endtask : s_block_read

  // an absent or foreign slave never pulls the acknowledge slot
  task automatic s_no_answer();
    mute = 1'b1;
    run_op(2'h0, 7'h02, 8'h00, 8'h3c, 11);
    check("nack", 8'h01, nack);
    check("mem2", 8'h33, u_scs_dev_model.mem[2]);
    mute = 1'b0;
  endtask : s_no_answer

  initial begin
    tick(5);
    reset_in = 1'b0;
    tick(1);
    s_reset();
    slow = 1'b1;
    s_byte_read(7'h01, 8'h7f);
    slow = 1'b0;
    s_byte_write();
    s_block_write();
    s_block_read();
    s_no_answer();
    s_byte_read(7'h02, 8'h33);
    final_report();
  end

  initial begin
    #4500000;
    mismatches++;
    final_report();
  end
endmodule : tb
